// *** hdl/pmc_consts.vh ***
// Constants shared by the power-mode controller design files.
//
// Overview of operation
// - Three modes: Active, Sleep, Deep Sleep; controller-managed.
// - Active keeps every subsystem clock enabled.
// - Sleep gates processor, flash, SRAM; instant wake.
// - Deep Sleep stops high-speed clock and dependents.
// - Deep Sleep wake completes within 35 us.
// - Hold mode entry until supplies are adequate; a Deep Sleep wake that runs out of wake budget enters Active without supply_ok.
// - Brown-out detection issues a device reset.
// - Wakeup interrupt unit wakes processor from Deep Sleep.
// - Deep Sleep exit on enabled interrupt or address match.
// - Nested interrupt controller has eight request inputs.
// - Low-frequency oscillator keeps running in Deep Sleep.
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH

// ----------------------------------------------------------------
// Mode codes shown on the mode output
// ----------------------------------------------------------------
`define PMC_MODE_ACTIVE     2'h0
`define PMC_MODE_SLEEP      2'h1
`define PMC_MODE_DEEP       2'h2

// ----------------------------------------------------------------
// Interrupt and timing figures
// ----------------------------------------------------------------
`define PMC_NUM_IRQ         8
`define PMC_CLK_MHZ         20
`define PMC_WAKE_US         35
`define PMC_WAKE_CYC        (`PMC_WAKE_US * `PMC_CLK_MHZ)
`define PMC_SETTLE_CYC      16
`define PMC_BOR_RST_CYC     8

`endif

// *** hdl/pmc_wake_unit.v ***
// Wakeup interrupt unit: latches enabled requests and address match.
`include "pmc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module pmc_wake_unit #(
  parameter NUM_IRQ = `PMC_NUM_IRQ
) (
  // Clock and reset
  input  wire               sys_clk,
  input  wire               rst,
  // Control
  input  wire               arm,
  input  wire               clear,
  // Wake sources
  input  wire [NUM_IRQ-1:0] irq_req,
  input  wire [NUM_IRQ-1:0] irq_en,
  input  wire               addr_match,
  // Result
  output reg                wake_pend_reg
);

  wire [NUM_IRQ-1:0] hit;

  // Per-line qualification of each request by its enable.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi = gi + 1) begin : g_line
      assign hit[gi] = irq_req[gi] & irq_en[gi];
    end
  endgenerate

  // Sticky wake flag; an armed source arriving with the clear still sets it.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wake_pend_reg <= 1'b0;
    end else if (arm && ((|hit) || addr_match)) begin
      wake_pend_reg <= 1'b1;
    end else if (clear) begin
      wake_pend_reg <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** hdl/pmc_top.v ***
// Power-mode controller: Active, Sleep and Deep Sleep sequencing.
`include "pmc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module pmc_top #(
  parameter NUM_IRQ   = `PMC_NUM_IRQ,
  parameter WAKE_CYC  = `PMC_WAKE_CYC,
  parameter SETTLE    = `PMC_SETTLE_CYC,
  parameter BOR_CYC   = `PMC_BOR_RST_CYC
) (
  // Clock and reset
  input  wire               sys_clk,
  input  wire               rst,
  // Supply monitors
  input  wire               supply_ok,
  input  wire               brownout,
  // Processor requests
  input  wire               sleep_req,
  input  wire               deep_req,
  // Wake sources
  input  wire [NUM_IRQ-1:0] irq_req,
  input  wire [NUM_IRQ-1:0] irq_en,
  input  wire               addr_match,
  // High-speed oscillator status
  input  wire               hf_stable,
  // Clock gates and status
  output reg                cpu_clk_en_reg,
  output reg                flash_clk_en_reg,
  output reg                sram_clk_en_reg,
  output reg                periph_clk_en_reg,
  output reg                hf_osc_en_reg,
  output reg                lf_osc_en_reg,
  output reg                cpu_pwr_en_reg,
  output reg                dev_rst_reg,
  output reg [1:0]          mode_reg,
  output reg                wake_late_reg
);

  // ----------------------------------------------------------------
  // State encoding
  // ----------------------------------------------------------------
  localparam [2:0] ST_HOLD   = 3'h0;
  localparam [2:0] ST_ACTIVE = 3'h1;
  localparam [2:0] ST_SLEEP  = 3'h2;
  localparam [2:0] ST_DEEP   = 3'h3;
  localparam [2:0] ST_HFUP   = 3'h4;
  localparam [2:0] ST_BOR    = 3'h5;

  // Full-width copies so the 16-bit limits are cut on purpose.
  localparam [31:0] WAKE_W     = WAKE_CYC;
  localparam [31:0] SETTLE_W   = SETTLE;
  localparam [31:0] BOR_W      = BOR_CYC;
  localparam [15:0] WAKE_LIM   = WAKE_W[15:0];
  localparam [15:0] SETTLE_LIM = SETTLE_W[15:0];
  localparam [15:0] BOR_LIM    = BOR_W[15:0];

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [15:0] cnt_reg;
  reg  [15:0] cnt_next;
  wire        wake_pend;
  wire        deep_arm;
  wire        wake_clear;
  wire        any_wake;

  // ----------------------------------------------------------------
  // Wake source latch
  // ----------------------------------------------------------------
  assign deep_arm   = (state_reg == ST_DEEP);
  assign wake_clear = (state_reg == ST_ACTIVE);
  assign any_wake   = |(irq_req & irq_en);

  pmc_wake_unit #(
    .NUM_IRQ (NUM_IRQ)
  ) u_wake (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .arm           (deep_arm),
    .clear         (wake_clear),
    .irq_req       (irq_req),
    .irq_en        (irq_en),
    .addr_match    (addr_match),
    .wake_pend_reg (wake_pend)
  );

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------

  // Next-state logic for the three modes and their transitions.
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_HOLD: begin
        cnt_next = 16'h0000;
        if (supply_ok) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (deep_req) begin
          state_next = ST_DEEP;
        end else if (sleep_req && !any_wake) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (any_wake) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_DEEP: begin
        cnt_next = 16'h0000;
        if (wake_pend) begin
          state_next = ST_HFUP;
        end
      end
      ST_HFUP: begin
        cnt_next = cnt_reg + 16'h0001;
        // Oscillator must be stable and have settled a few cycles.
        if (hf_stable && (cnt_reg >= SETTLE_LIM) && supply_ok) begin
          state_next = ST_ACTIVE;
        end else if (cnt_reg >= WAKE_LIM - 16'h0001) begin
          // Give up waiting past the wake budget and run anyway.
          state_next = ST_ACTIVE;
        end
      end
      ST_BOR: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg >= BOR_LIM - 16'h0001) begin
          state_next = ST_HOLD;
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
    if (brownout) begin
      state_next = ST_BOR;
      cnt_next   = (state_reg == ST_BOR) ? 16'h0000 : 16'h0000;
    end
  end

  // State and counter registers.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_HOLD;
      cnt_reg   <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------

  // Clock gates, oscillator enables, reset and mode from next state.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cpu_clk_en_reg    <= 1'b0;
      flash_clk_en_reg  <= 1'b0;
      sram_clk_en_reg   <= 1'b0;
      periph_clk_en_reg <= 1'b0;
      hf_osc_en_reg     <= 1'b1;
      lf_osc_en_reg     <= 1'b1;
      cpu_pwr_en_reg    <= 1'b1;
      dev_rst_reg       <= 1'b1;
      mode_reg          <= `PMC_MODE_ACTIVE;
      wake_late_reg     <= 1'b0;
    end else begin
      cpu_clk_en_reg    <= (state_next == ST_ACTIVE);
      flash_clk_en_reg  <= (state_next == ST_ACTIVE);
      sram_clk_en_reg   <= (state_next == ST_ACTIVE);
      periph_clk_en_reg <= (state_next == ST_ACTIVE) ||
                           (state_next == ST_SLEEP);
      hf_osc_en_reg     <= (state_next != ST_DEEP);
      lf_osc_en_reg     <= 1'b1;
      cpu_pwr_en_reg    <= (state_next != ST_DEEP);
      dev_rst_reg       <= (state_next == ST_HOLD) ||
                           (state_next == ST_BOR);
      if (state_next == ST_SLEEP) begin
        mode_reg <= `PMC_MODE_SLEEP;
      end else if ((state_next == ST_DEEP) || (state_next == ST_HFUP)) begin
        mode_reg <= `PMC_MODE_DEEP;
      end else begin
        mode_reg <= `PMC_MODE_ACTIVE;
      end
      // Flags a wake that ran out of budget before the clock was stable.
      wake_late_reg     <= (state_reg == ST_HFUP) && (state_next == ST_ACTIVE) &&
                           !hf_stable;
    end
  end

endmodule

`default_nettype wire

// *** bench/pmc_osc_model.sv ***
// Behavioural high-speed oscillator that reports stability after a start-up delay.
`timescale 1ns/1ps
`default_nettype none
module pmc_osc_model #(parameter int DLY = 4) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Oscillator control
  input  wire logic hf_osc_en,
  input  wire logic slow,
  // Status
  output var  logic hf_stable
);
  logic [3:0] cnt_reg;
  // Counts running cycles; a stopped or slow oscillator never reports stable.
  always @(posedge sys_clk or posedge rst) begin
    if (rst || !hf_osc_en) cnt_reg <= 4'h0;
    else if (!slow && cnt_reg < DLY) cnt_reg <= cnt_reg + 4'h1;
  end
  assign hf_stable = hf_osc_en && !slow && cnt_reg == DLY;
endmodule
`default_nettype wire

// *** bench/pmc_assertions.sv ***
// Concurrent checks on the ports of the power-mode controller.
`timescale 1ns/1ps
`default_nettype none
module pmc_assertions #(parameter NUM_IRQ = 8, parameter WAKE_CYC = 700) (
  // Inputs of the controller
  input wire logic sys_clk, rst, supply_ok, brownout, sleep_req, deep_req,
  input wire logic [NUM_IRQ-1:0] irq_req, irq_en,
  input wire logic addr_match, hf_stable,
  // Outputs of the controller
  input wire logic cpu_clk_en_reg, flash_clk_en_reg, sram_clk_en_reg, periph_clk_en_reg,
  input wire logic hf_osc_en_reg, lf_osc_en_reg, cpu_pwr_en_reg, dev_rst_reg,
  input wire logic [1:0] mode_reg,
  input wire logic wake_late_reg
);
  localparam int WMAX = WAKE_CYC + 4;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_MODE_LEGAL: assert property (mode_reg != 2'h3) else $error("Illegal mode code.");
  AST_ACTIVE_CLK: assert property (mode_reg == 2'h0 && !dev_rst_reg |-> cpu_clk_en_reg
    && flash_clk_en_reg && sram_clk_en_reg && periph_clk_en_reg) else $error("Gate off.");
  AST_SLEEP_GATE: assert property (mode_reg == 2'h1 |-> !cpu_clk_en_reg && !flash_clk_en_reg
    && !sram_clk_en_reg && periph_clk_en_reg) else $error("Sleep gating wrong.");
  AST_SLEEP_WAKE: assert property (mode_reg == 2'h1 && |(irq_req & irq_en) && !brownout
    |-> ##[1:2] mode_reg == 2'h0) else $error("Slow sleep wake.");
  AST_DEEP_ENTRY: assert property ($past(mode_reg) == 2'h0 && mode_reg == 2'h2
    |-> !hf_osc_en_reg && !cpu_clk_en_reg) else $error("Clock on in deep.");
  AST_DEEP_WAKE: assert property (mode_reg == 2'h2 && !cpu_pwr_en_reg && |(irq_req & irq_en)
    |-> ##[1:WMAX] mode_reg == 2'h0) else $error("Deep wake too slow.");
  AST_ADDR_WAKE: assert property (mode_reg == 2'h2 && !cpu_pwr_en_reg && addr_match
    |-> ##[1:3] hf_osc_en_reg) else $error("No restart on match.");
  AST_LF_ON: assert property (lf_osc_en_reg) else $error("Slow oscillator off.");
  AST_HOLD: assert property (dev_rst_reg && !supply_ok |=> dev_rst_reg)
    else $error("Left hold-off early.");
  AST_BOR: assert property (brownout |=> dev_rst_reg) else $error("No brown-out reset.");
  AST_HF_READY: assert property ($past(mode_reg) == 2'h2 && mode_reg == 2'h0 && !wake_late_reg
    |-> $past(hf_stable)) else $error("Ungated before stable.");
  // Main scenarios reached.
  COV_SLEEP: cover property (mode_reg == 2'h1);
  COV_DEEP: cover property (mode_reg == 2'h2 && !cpu_pwr_en_reg);
  COV_LATE: cover property (wake_late_reg);
endmodule
bind pmc_top pmc_assertions #(.NUM_IRQ(NUM_IRQ), .WAKE_CYC(WAKE_CYC)) pmc_assertions_inst (.*);
`default_nettype wire

// *** bench/tb_pmc_top.sv ***
// Self-checking testbench for the power-mode controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_pmc_top;
  logic sys_clk = 0, rst = 1, supply_ok = 0, brownout = 0, sleep_req = 0, deep_req = 0;
  logic addr_match = 0, slow = 0, hf_stable, cpu_clk_en_reg, flash_clk_en_reg;
  logic sram_clk_en_reg, periph_clk_en_reg, hf_osc_en_reg, lf_osc_en_reg, cpu_pwr_en_reg;
  logic dev_rst_reg, wake_late_reg;
  logic [7:0] irq_req = 8'h00, irq_en = 8'h00;
  logic [1:0] mode_reg, late_cnt = 2'h0;
  int miscompares = 0, checked = 0, i;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wake_late_reg) late_cnt <= late_cnt + 2'h1;
  pmc_top #(.WAKE_CYC(40), .SETTLE(2)) pmc_top_inst (.*);
  pmc_osc_model pmc_osc_model_inst (.sys_clk, .rst, .hf_osc_en(hf_osc_en_reg), .slow, .hf_stable);
  task automatic conclude;
    $display("Counts: checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Waits a bounded number of cycles for a mode; running out ends the run.
  task automatic wait_mode(input logic [1:0] m, input int n);
    for (int k = 0; k < n && mode_reg !== m; k++) @(negedge sys_clk);
    `CHK(mode_reg, m)
    if (mode_reg !== m) conclude();
  endtask
  task automatic t_hold;
    repeat (6) @(negedge sys_clk);
    `CHK({dev_rst_reg, cpu_clk_en_reg}, 2'h2)
    supply_ok = 1;
    repeat (3) @(negedge sys_clk);
    `CHK({dev_rst_reg, cpu_clk_en_reg, flash_clk_en_reg, sram_clk_en_reg, periph_clk_en_reg}, 5'h0f)
    $display("t_hold done");
  endtask
  task automatic t_sleep;
    for (i = 0; i < 8; i++) begin
      irq_en = 8'h01 << i;
      sleep_req = 1;
      wait_mode(2'h1, 4);
      sleep_req = 0;
      `CHK({cpu_clk_en_reg, flash_clk_en_reg, sram_clk_en_reg, periph_clk_en_reg}, 4'h1)
      irq_req = ~irq_en;
      repeat (2) @(negedge sys_clk);
      `CHK(mode_reg, 2'h1)
      irq_req = irq_en;
      wait_mode(2'h0, 3);
      irq_req = 8'h00;
      @(negedge sys_clk);
    end
    $display("t_sleep done");
  endtask
  task automatic t_deep(input logic is_slow, input logic use_addr);
    logic [1:0] late0;
    slow = is_slow;
    late0 = late_cnt;
    deep_req = 1;
    wait_mode(2'h2, 4);
    deep_req = 0;
    `CHK({hf_osc_en_reg, cpu_pwr_en_reg, cpu_clk_en_reg, lf_osc_en_reg}, 4'h1)
    irq_en = 8'h80;
    irq_req = 8'h40;
    repeat (3) @(negedge sys_clk);
    `CHK(mode_reg, 2'h2)
    addr_match = use_addr;
    irq_req = use_addr ? 8'h00 : 8'h80;
    @(negedge sys_clk);
    addr_match = 0;
    irq_req = 8'h00;
    wait_mode(2'h0, 44);
    @(negedge sys_clk);
    `CHK({late_cnt - late0, hf_stable}, is_slow ? 3'h2 : 3'h1)
    $display("t_deep done");
  endtask
  task automatic t_bor;
    slow = 0;
    brownout = 1;
    @(negedge sys_clk);
    brownout = 0;
    @(negedge sys_clk);
    `CHK({dev_rst_reg, cpu_clk_en_reg}, 2'h2)
    for (i = 0; i < 20 && dev_rst_reg !== 1'b0; i++) @(negedge sys_clk);
    `CHK({dev_rst_reg, mode_reg, cpu_clk_en_reg}, 4'h1)
    $display("t_bor done");
  endtask
  // A sleep request with an enabled interrupt pending is refused.
  task automatic t_refuse;
    irq_en = 8'h01;
    irq_req = 8'h01;
    sleep_req = 1;
    repeat (3) @(negedge sys_clk);
    `CHK({mode_reg, cpu_clk_en_reg}, 3'h1)
    sleep_req = 0;
    irq_req = 8'h00;
    @(negedge sys_clk);
    $display("t_refuse done");
  endtask
  initial begin
    repeat (6) @(negedge sys_clk);
    rst = 0;
    t_hold;
    t_sleep;
    t_deep(1'b0, 1'b1);
    t_deep(1'b1, 1'b0);
    t_bor;
    t_refuse;
    conclude;
  end
endmodule
`default_nettype wire
